//--- design/plc_pkg.sv
// plc_pkg: constants, codes and carrier types of the link interface compatibility block
// assumes: used by plc_link_compat and its testbench, every use written plc_pkg::name
package plc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LAST_REQ = 4'h8;
  // config fields
  localparam int CFG_ARB_ACCEL_BIT = 0;
  localparam int CFG_CONCAT_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // status fields
  localparam int STS_NEWER_BIT = 0;
  localparam int STS_LOCKED_BIT = 1;
  localparam int STS_ISOLATION_BIT = 2;
  localparam int STS_NULL_CNT_LSB = 8;
  localparam logic STS_ISOLATION_SUPPORT = 1'b0;
  // request type codes, sent msb first after the start bit
  localparam logic [2:0] REQ_IMMEDIATE = 3'h0;
  localparam logic [2:0] REQ_ISOCH = 3'h1;
  localparam logic [2:0] REQ_PRIORITY = 3'h2;
  localparam logic [2:0] REQ_FAIR = 3'h3;
  localparam logic [2:0] REQ_REG_READ = 3'h4;
  localparam logic [2:0] REQ_REG_WRITE = 3'h5;
  localparam logic [2:0] REQ_ACCEL_CTL = 3'h6;
  // bit index at which each request is complete
  localparam logic [3:0] IDX_TYPE_END = 4'h2;
  localparam logic [3:0] IDX_ACCEL_END = 4'h3;
  localparam logic [3:0] IDX_SPEED_LAST = 4'h5;
  localparam logic [3:0] IDX_SPEED_LONG = 4'h6;
  localparam logic [3:0] IDX_READ_END = 4'h6;
  localparam logic [3:0] IDX_WRITE_END = 4'hE;
  // three-bit speed codes; two-bit codes gain a trailing zero
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h2;
  localparam logic [2:0] SPD_S400 = 3'h4;
  // control and data values of the empty packet
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [7:0] DATA_PREFIX = 8'hFF;
  localparam logic [7:0] DATA_IDLE = 8'h00;
  // edges after reset release before the strap chain holds pin samples
  localparam logic [1:0] STRAP_FILL = 2'h3;
  // decoded request carried to the rest of the node
  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] speed;
    logic long_form;
    logic [3:0] addr;
    logic [7:0] data;
  } plc_req_type;
endpackage

//--- design/plc_link_compat.sv
// plc_link_compat: strap-selected link interface mode, legacy request decoder,
// empty-packet answer to over-speed requests, avalon-mm control registers
// assumes: core_clk is the interface clock shared with the link controller
`timescale 1ns/1ps
module plc_link_compat (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // strap pin
  input wire logic interface_generation_select,
  // link request line
  input wire logic lreq,
  // link control and data pins, driven side only
  output logic [1:0] ctl_out,
  output logic ctl_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  // decoded requests, mode and config enables
  output logic req_valid,
  output plc_pkg::plc_req_type req,
  output logic mode_newer,
  output logic mode_locked,
  output logic arb_accel_enable,
  output logic multispeed_concat_enable,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [1:0] {DEC_IDLE, DEC_COLLECT, DEC_TAIL} plc_dec_type;
  typedef enum logic [1:0] {TX_IDLE, TX_PREFIX, TX_END} plc_tx_type;

  // three-bit code legal on the legacy interface
  function automatic logic legacy_speed_ok(input logic [2:0] spd);
    legacy_speed_ok = (spd == plc_pkg::SPD_S100) || (spd == plc_pkg::SPD_S200) ||
                      (spd == plc_pkg::SPD_S400);
  endfunction

  logic [2:0] strap_sync, next_strap_sync;
  logic [1:0] fill, next_fill;
  logic next_mode_newer, next_mode_locked;
  plc_dec_type dec_state, next_dec_state;
  logic [3:0] cnt, next_cnt;
  logic [15:0] sr, next_sr;
  logic [15:0] cur;
  logic [2:0] cur_type;
  logic next_req_valid;
  plc_pkg::plc_req_type next_req;
  plc_pkg::plc_req_type dec_req;
  logic null_start;
  plc_tx_type tx_state, next_tx_state;
  logic [7:0] null_cnt, next_null_cnt;
  logic [1:0] cfg, next_cfg;
  logic ack, next_ack;
  logic [31:0] next_readdata;

  // strap synchroniser and one-shot capture after reset release
  always_comb
  begin
    next_strap_sync = {strap_sync[1:0], interface_generation_select};
    next_fill = (fill == plc_pkg::STRAP_FILL) ? fill : fill + 2'h1;
    next_mode_newer = mode_newer;
    next_mode_locked = mode_locked;
    // reset zeros in the chain agree trivially, so wait until it holds pin samples
    if (!mode_locked && fill == plc_pkg::STRAP_FILL && (strap_sync[1] == strap_sync[2]))
    begin
      next_mode_newer = strap_sync[2];
      next_mode_locked = 1'b1;
    end
  end

  // bit being received merged into the collected bits
  always_comb
  begin
    cur = sr;
    cur[cnt] = lreq;
    cur_type = {cur[0], cur[1], cur[2]};
  end

  // legacy request decoder
  always_comb
  begin
    next_dec_state = dec_state;
    next_cnt = cnt;
    next_sr = cur;
    next_req_valid = 1'b0;
    next_req = req;
    dec_req = req;
    null_start = 1'b0;
    unique case (dec_state)
      DEC_IDLE:
      begin
        next_sr = '0;
        next_cnt = 4'h0;
        if (lreq && mode_locked && !mode_newer)
          next_dec_state = DEC_COLLECT;
      end
      DEC_COLLECT:
      begin
        next_cnt = cnt + 4'h1;
        dec_req.kind = cur_type;
        dec_req.speed = {cur[3], cur[4], cur[5]};
        dec_req.long_form = 1'b0;
        dec_req.addr = {cur[3], cur[4], cur[5], cur[6]};
        dec_req.data = {cur[7], cur[8], cur[9], cur[10], cur[11], cur[12], cur[13], cur[14]};
        if (cur_type[2] == 1'b0)
        begin
          // bus request: a zero sixth bit ends a short one, a one sixth bit runs on to a long one's seventh
          if ((cnt == plc_pkg::IDX_SPEED_LAST && !lreq) || cnt == plc_pkg::IDX_SPEED_LONG)
          begin
            dec_req.long_form = (cnt == plc_pkg::IDX_SPEED_LONG);
            next_dec_state = DEC_TAIL;
            if (legacy_speed_ok(dec_req.speed))
              next_req_valid = 1'b1;
            else
              null_start = 1'b1;
          end
        end
        else if ((cur_type == plc_pkg::REQ_REG_READ && cnt == plc_pkg::IDX_READ_END) ||
                 (cur_type == plc_pkg::REQ_REG_WRITE && cnt == plc_pkg::IDX_WRITE_END) ||
                 (cur_type == plc_pkg::REQ_ACCEL_CTL && cnt == plc_pkg::IDX_ACCEL_END))
        begin
          next_req_valid = 1'b1;
          next_dec_state = DEC_TAIL;
        end
        else if (cur_type == 3'h7 && cnt == plc_pkg::IDX_TYPE_END)
          next_dec_state = DEC_TAIL; // reserved type dropped
      end
      DEC_TAIL:
      begin
        // stop bit, or the start bit of a request sent back to back
        next_sr = '0;
        next_cnt = 4'h0;
        next_dec_state = lreq ? DEC_COLLECT : DEC_IDLE;
      end
    endcase
    // the last request stands until a new one is complete
    if (next_req_valid)
      next_req = dec_req;
  end

  // empty packet transmitter
  always_comb
  begin
    next_tx_state = tx_state;
    next_null_cnt = null_cnt;
    unique case (tx_state)
      TX_IDLE:
        if (null_start)
        begin
          next_tx_state = TX_PREFIX;
          next_null_cnt = null_cnt + 8'h01;
        end
      TX_PREFIX: next_tx_state = TX_END;
      TX_END: next_tx_state = TX_IDLE;
    endcase
  end

  // register slave, one wait state per access
  always_comb
  begin
    next_ack = (avs_read || avs_write) && !ack;
    next_cfg = cfg;
    next_readdata = avs_readdata;
    if (avs_write && ack && avs_address == plc_pkg::OFS_CONFIG)
      next_cfg = avs_writedata[1:0];
    if (avs_read && !ack)
    begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address)
        plc_pkg::OFS_CONFIG: next_readdata[1:0] = cfg;
        plc_pkg::OFS_STATUS:
        begin
          next_readdata[plc_pkg::STS_NEWER_BIT] = mode_newer;
          next_readdata[plc_pkg::STS_LOCKED_BIT] = mode_locked;
          next_readdata[plc_pkg::STS_ISOLATION_BIT] = plc_pkg::STS_ISOLATION_SUPPORT;
          next_readdata[plc_pkg::STS_NULL_CNT_LSB +: 8] = null_cnt;
        end
        plc_pkg::OFS_LAST_REQ: next_readdata[18:0] = req;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign arb_accel_enable = cfg[plc_pkg::CFG_ARB_ACCEL_BIT];
  assign multispeed_concat_enable = cfg[plc_pkg::CFG_CONCAT_BIT];

  // all state on the rising interface clock edge
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_sync <= 3'h0;
      fill <= 2'h0;
      mode_newer <= 1'b0;
      mode_locked <= 1'b0;
      dec_state <= DEC_IDLE;
      cnt <= 4'h0;
      sr <= 16'h0000;
      req_valid <= 1'b0;
      req <= '0;
      tx_state <= TX_IDLE;
      null_cnt <= 8'h00;
      cfg <= plc_pkg::CFG_RESET;
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      ctl_out <= plc_pkg::CTL_IDLE;
      ctl_oe <= 1'b0;
      data_out <= plc_pkg::DATA_IDLE;
      data_oe <= 1'b0;
    end
    else
    begin
      strap_sync <= next_strap_sync;
      fill <= next_fill;
      mode_newer <= next_mode_newer;
      mode_locked <= next_mode_locked;
      dec_state <= next_dec_state;
      cnt <= next_cnt;
      sr <= next_sr;
      req_valid <= next_req_valid;
      req <= next_req;
      tx_state <= next_tx_state;
      null_cnt <= next_null_cnt;
      cfg <= next_cfg;
      ack <= next_ack;
      avs_readdata <= next_readdata;
      ctl_out <= (next_tx_state == TX_PREFIX) ? plc_pkg::CTL_RECEIVE : plc_pkg::CTL_IDLE;
      ctl_oe <= (next_tx_state != TX_IDLE);
      data_out <= (next_tx_state == TX_PREFIX) ? plc_pkg::DATA_PREFIX : plc_pkg::DATA_IDLE;
      data_oe <= (next_tx_state != TX_IDLE);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence null_prefix_s;
    ctl_oe && ctl_out == plc_pkg::CTL_RECEIVE && data_out == plc_pkg::DATA_PREFIX;
  endsequence
  sequence null_end_s;
    ctl_oe && ctl_out == plc_pkg::CTL_IDLE && data_out == plc_pkg::DATA_IDLE;
  endsequence

  mode_hold_a: assert property (mode_locked |=> mode_locked && $stable(mode_newer))
    else $error("interface mode changed after capture");
  newer_quiet_a: assert property (mode_newer |=> !req_valid && !ctl_oe)
    else $error("legacy decoder active in newer mode");
  legacy_only_a: assert property (req_valid |-> mode_locked && !mode_newer)
    else $error("request decoded outside legacy mode");
  short_req_a: assert property (dec_state == DEC_COLLECT && cur_type[2] == 1'b0 &&
      cnt == plc_pkg::IDX_SPEED_LAST && !lreq && legacy_speed_ok({cur[3], cur[4], 1'b0})
      |=> req_valid && !req.long_form && req.speed == $past({cur[3], cur[4], 1'b0}))
    else $error("short bus request not decoded");
  long_req_a: assert property (dec_state == DEC_COLLECT && cur_type[2] == 1'b0 &&
      cnt == plc_pkg::IDX_SPEED_LONG |=> (req_valid && req.long_form) || (ctl_oe && !req_valid))
    else $error("long bus request not decoded");
  back_to_back_a: assert property (dec_state == DEC_TAIL && lreq
      |=> dec_state == DEC_COLLECT && cnt == 4'h0)
    else $error("request after short request lost");
  null_packet_a: assert property (null_start |=> !req_valid ##0 null_prefix_s ##1 null_end_s
      ##1 !ctl_oe)
    else $error("empty packet sequence wrong");
  speed_agree_a: assert property (req_valid && req.kind[2] == 1'b0
      |-> legacy_speed_ok(req.speed) && (req.long_form || req.speed[0] == 1'b0))
    else $error("bus request speed outside S100 to S400");
  edge_launch_a: assert property (ctl_oe |-> $past(tx_state == TX_IDLE) ? $past(null_start, 1)
      : 1'b1)
    else $error("link pins driven without a cause");
endmodule

//--- test/plc_link_model.sv
// plc_link_model: link controller side, sends serial requests on lreq
// assumes: shares core_clk with the device; lreq rests low between requests
`timescale 1ns/1ps
module plc_link_model (
  // clock
  input wire logic core_clk,
  // request line
  output logic lreq
);
  // link clock pin held at ground in legacy mode, never toggled
  logic link_clock_in = 1'b0;
  initial lreq = 1'b0;
  // shift n bits msb first, one per rising edge, then a stop bit low
  task automatic send(input logic [15:0] b, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge core_clk);
      lreq <= b[i];
    end
    @(posedge core_clk);
    lreq <= 1'b0;
  endtask
endmodule

//--- test/plc_link_compat_tb.sv
// plc_link_compat_tb: legacy decoding, empty packets, strap mode and registers
// assumes: plc_link_model drives lreq, core_clk at 100 MHz
`timescale 1ns/1ps
module plc_link_compat_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic lreq, ctl_oe, data_oe, req_valid, mode_newer, mode_locked, arb_en, concat_en;
  logic [1:0] ctl_out;
  logic [7:0] data_out, d;
  plc_pkg::plc_req_type req, last;
  plc_pkg::plc_req_type got[$];
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest;
  logic [2:0] k, s;
  logic [3:0] a;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'hB37A;
  int nulls = 0;
  int pkts = 0;
  always #5 core_clk = ~core_clk;
  plc_link_compat u_plc_link_compat (.core_clk(core_clk), .reset_n(reset_n),
    .interface_generation_select(strap), .lreq(lreq), .ctl_out(ctl_out), .ctl_oe(ctl_oe),
    .data_out(data_out), .data_oe(data_oe), .req_valid(req_valid), .req(req),
    .mode_newer(mode_newer), .mode_locked(mode_locked), .arb_accel_enable(arb_en),
    .multispeed_concat_enable(concat_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  plc_link_model u_plc_link_model (.core_clk(core_clk), .lreq(lreq));
  // one compare for every kind of value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // speed codes that legacy mode forwards
  function automatic logic speed_ok(input logic [2:0] sp);
    return sp == plc_pkg::SPD_S100 || sp == plc_pkg::SPD_S200 || sp == plc_pkg::SPD_S400;
  endfunction
  // avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= ad;
    avs_writedata <= wd;
    // only the watchdog ends a wait that never sees waitrequest low
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic do_reset(input logic st);
    reset_n <= 1'b0;
    strap <= st;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  // collect decoded requests and check each empty packet
  always @(posedge core_clk)
  begin
    if (req_valid === 1'b1)
      got.push_back(req);
    if (ctl_oe === 1'b1 && ctl_out === plc_pkg::CTL_RECEIVE)
    begin
      pkts++;
      chk({data_oe, data_out}, {1'b1, plc_pkg::DATA_PREFIX});
      @(posedge core_clk);
      chk({ctl_oe, data_oe, ctl_out, data_out},
          {2'b11, plc_pkg::CTL_IDLE, plc_pkg::DATA_IDLE});
      @(posedge core_clk);
      chk({ctl_oe, data_oe}, 2'b00);
    end
  end
  // main sequence
  initial
  begin
    do_reset(1'b0);
    chk({mode_locked, mode_newer}, 2'b10);
    for (int i = 0; i < 8; i++)
    begin
      s = i[2:0];
      k = {1'b0, 2'($random(seed))};
      u_plc_link_model.send({1'b1, k, s}, 7);
      repeat (6) @(posedge core_clk);
      chk(got.size(), speed_ok(s));
      if (got.size() > 0)
        chk({got[0].kind, got[0].speed}, {k, s});
      else
        nulls++;
      got.delete();
    end
    chk(pkts, nulls);
    $display("long bus requests done");
    for (int i = 0; i < 3; i++)
    begin
      k = {1'b0, 2'($random(seed))};
      a = 4'($random(seed));
      u_plc_link_model.send({1'b1, k, i[1:0], 1'b0, 1'b1, plc_pkg::REQ_REG_READ, a}, 15);
      repeat (6) @(posedge core_clk);
      chk(got.size(), 2);
      if (got.size() == 2)
        chk({got[0].kind, got[0].speed, got[1].kind, got[1].addr},
            {k, i[1:0], 1'b0, plc_pkg::REQ_REG_READ, a});
      got.delete();
    end
    a = 4'($random(seed));
    d = 8'($random(seed));
    u_plc_link_model.send({1'b1, plc_pkg::REQ_REG_WRITE, a, d}, 16);
    // reserved type in between is dropped without a pulse
    u_plc_link_model.send({1'b1, 3'h7}, 4);
    u_plc_link_model.send({1'b1, plc_pkg::REQ_ACCEL_CTL, 1'b1}, 5);
    repeat (6) @(posedge core_clk);
    chk(got.size(), 2);
    last = got[got.size() - 1];
    if (got.size() == 2)
      chk({got[0].kind, got[0].addr, got[0].data, last.kind, last.addr[3]},
          {plc_pkg::REQ_REG_WRITE, a, d, plc_pkg::REQ_ACCEL_CTL, 1'b1});
    got.delete();
    $display("short and register requests done");
    av(1'b0, plc_pkg::OFS_STATUS, 32'h0);
    chk({q[15:8], q[2:0]}, {8'(nulls), 3'b010});
    av(1'b0, plc_pkg::OFS_LAST_REQ, 32'h0);
    chk(q[18:0], {plc_pkg::REQ_ACCEL_CTL, 3'h4, 1'b0, 4'h8, 8'h00});
    for (int i = 0; i < 4; i++)
    begin
      av(1'b1, plc_pkg::OFS_CONFIG, {30'($random(seed)), i[1:0]});
      av(1'b0, plc_pkg::OFS_CONFIG, 32'h0);
      chk(q, {30'h0, i[1:0]});
      chk({concat_en, arb_en}, i[1:0]);
    end
    av(1'b1, plc_pkg::OFS_STATUS, 32'hFFFFFFFF);
    av(1'b1, plc_pkg::OFS_CONFIG, 32'h0);
    av(1'b0, plc_pkg::OFS_STATUS, 32'h0);
    chk(q[2:0], 3'b010);
    av(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    $display("register tests done");
    do_reset(1'b1);
    strap <= 1'b0;
    u_plc_link_model.send({1'b1, plc_pkg::REQ_FAIR, plc_pkg::SPD_S200}, 7);
    u_plc_link_model.send({1'b1, plc_pkg::REQ_IMMEDIATE, 3'h7}, 7);
    repeat (8) @(posedge core_clk);
    chk(got.size(), 0);
    chk(pkts, nulls);
    chk({mode_locked, mode_newer}, 2'b11);
    av(1'b0, plc_pkg::OFS_STATUS, 32'h0);
    chk(q[2:0], 3'b011);
    $display("newer mode done");
    wrap_up();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #200000;
    num_errors++;
    $display("ERROR at %0t: timeout", $time);
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
